//--- sysclk_pkg.sv
// Constants, field layouts and carrier types for the clock and sleep control block
package sysclk_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam int          AXI_ADDR_W                   = 8;
  localparam int          AXI_DATA_W                   = 32;
  localparam logic [7:0]  CLOCK_DIVIDER_CONTROL_OFFSET = 8'h00;
  localparam logic [7:0]  SLEEP_CONTROL_OFFSET         = 8'h04;
  localparam logic [7:0]  PORT_CONFIG_OFFSET           = 8'h08;
  localparam logic [7:0]  STATUS_OFFSET                = 8'h0c;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int          DIVIDER_CHANGE_ENABLE_BIT    = 7;
  localparam int          DIVISION_SELECT_LSB          = 0;
  localparam int          DIVISION_SELECT_W            = 4;
  localparam int          SLEEP_ENABLE_BIT             = 0;
  localparam int          MODE_SELECT_LSB              = 1;
  localparam int          MODE_SELECT_W                = 3;
  localparam int          OSC_ENABLE_BIT               = 0;
  localparam int          EXT_CLOCK_BIT                = 1;
  localparam int          STATUS_PHASE_LSB             = 4;
  localparam int          STATUS_ACTIVE_DIV_LSB        = 0;

  // ------------------------------------------------------------
  // Reset and special values
  // ------------------------------------------------------------
  localparam logic [3:0]  DIVISION_SELECT_RESET        = 4'h0;
  localparam logic [3:0]  DIVISION_SELECT_FUSED        = 4'h3;
  localparam logic [3:0]  DIVISION_SELECT_MAX          = 4'h8;
  localparam logic [7:0]  UNLOCK_PATTERN               = 8'h80;
  localparam logic [3:0]  SLEEP_CONTROL_RESET          = 4'h0;
  localparam logic [1:0]  RESP_OKAY                    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR                  = 2'h2;

  // ------------------------------------------------------------
  // Sleep mode codes
  // ------------------------------------------------------------
  localparam logic [2:0]  MODE_IDLE                    = 3'h0;
  localparam logic [2:0]  MODE_NOISE_REDUCTION         = 3'h1;
  localparam logic [2:0]  MODE_POWER_DOWN              = 3'h2;
  localparam logic [2:0]  MODE_POWER_SAVE              = 3'h3;
  localparam logic [2:0]  MODE_STANDBY                 = 3'h6;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int          CLK_PERIOD_NS                = 20;
  localparam logic [2:0]  CHANGE_WINDOW_CYCLES         = 3'h4;
  localparam logic [2:0]  WAKE_HOLD_CYCLES             = 3'h4;
  localparam int          STARTUP_CK                   = 6;
  localparam logic [1:0]  STRAP_SETTLE_CYCLES          = 2'h2;

  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {PH_RUN, PH_SLEEP, PH_START, PH_HOLD} sleep_phase_t;

  typedef struct packed {
    logic                  awvalid;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic                  wvalid;
    logic [AXI_DATA_W-1:0] wdata;
    logic [3:0]            wstrb;
    logic                  bready;
    logic                  arvalid;
    logic [AXI_ADDR_W-1:0] araddr;
    logic                  rready;
  } axi_req_t;

  typedef struct packed {
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0]            rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic core_clock;
    logic program_memory_clock;
    logic peripheral_clock;
    logic converter_clock;
    logic async_clock;
  } clock_gates_t;

endpackage

//--- sysclk_prescale_sleep_ctrl.sv
// System clock prescaler, clock output, slow oscillator pin sharing and sleep control
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps

module sysclk_prescale_sleep_ctrl #(
  parameter int STARTUP_CYCLES = sysclk_pkg::STARTUP_CK
) (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    clk_en,
  input  wire sysclk_pkg::axi_req_t    axi_req,
  output sysclk_pkg::axi_rsp_t         axi_rsp,
  input  wire logic                    clock_output_fuse,
  input  wire logic                    divide_by_eight_fuse,
  input  wire logic                    sleep_instr,
  input  wire logic                    wake_irq,
  input  wire logic                    adc_enabled,
  output logic                         system_clock_output_pin,
  output logic                         system_clock_output_oe,
  output logic                         port_g_bit_four_free,
  output logic                         port_g_bit_three_free,
  output logic                         sys_tick,
  output sysclk_pkg::clock_gates_t     clock_gates,
  output logic                         core_halted,
  output logic                         wake_resume,
  output logic                         adc_start_conversion
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic                              aw_got;
    logic [sysclk_pkg::AXI_ADDR_W-1:0] aw_addr;
    logic                              w_got;
    logic [sysclk_pkg::AXI_DATA_W-1:0] w_data;
    logic [3:0]                        w_strb;
    logic                              bvalid;
    logic [1:0]                        bresp;
    logic                              rvalid;
    logic [sysclk_pkg::AXI_DATA_W-1:0] rdata;
    logic [1:0]                        rresp;
    logic [1:0]                        strap_cnt;
    logic                              strap_s1;
    logic                              strap_s2;
    logic [3:0]                        div_sel;
    logic                              change_enable;
    logic [2:0]                        change_cnt;
    logic [3:0]                        active_div;
    logic [7:0]                        div_cnt;
    logic                              div_clk;
    logic [3:0]                        sleep_ctrl;
    logic                              osc_enable;
    logic                              ext_clock;
    sysclk_pkg::sleep_phase_t          phase;
    logic [15:0]                       wait_cnt;
    sysclk_pkg::clock_gates_t          gates;
    logic                              wake_resume;
    logic                              adc_start;
  } ctrl_state_t;

  ctrl_state_t st;
  ctrl_state_t next_st;

  localparam logic [15:0] STARTUP_COUNT = 16'(STARTUP_CYCLES);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic sysclk_pkg::clock_gates_t gates_for(input logic [2:0] mode);
    sysclk_pkg::clock_gates_t g;
    g = '0;
    case (mode)
      sysclk_pkg::MODE_IDLE: begin
        g.peripheral_clock = 1'b1;
        g.converter_clock  = 1'b1;
        g.async_clock      = 1'b1;
      end
      sysclk_pkg::MODE_NOISE_REDUCTION: begin
        g.converter_clock = 1'b1;
        g.async_clock     = 1'b1;
      end
      sysclk_pkg::MODE_POWER_SAVE: begin
        g.async_clock = 1'b1;
      end
      default: begin
        g = '0;
      end
    endcase
    return g;
  endfunction

  function automatic logic mode_legal(input logic [2:0] mode);
    return (mode == sysclk_pkg::MODE_IDLE) || (mode == sysclk_pkg::MODE_NOISE_REDUCTION) ||
           (mode == sysclk_pkg::MODE_POWER_DOWN) || (mode == sysclk_pkg::MODE_POWER_SAVE) ||
           (mode == sysclk_pkg::MODE_STANDBY);
  endfunction

  // Reserved codes divide by the largest legal factor
  function automatic logic [3:0] clamp_div(input logic [3:0] sel);
    return (sel > sysclk_pkg::DIVISION_SELECT_MAX) ? sysclk_pkg::DIVISION_SELECT_MAX : sel;
  endfunction

  logic [2:0] cur_mode;
  logic       aw_take;
  logic       w_take;
  logic       ar_take;
  logic       wr_go;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic       wr_lane0;
  logic [7:0] wr_byte;
  logic [7:0] period_last;
  logic [7:0] cnt_after;
  logic [3:0] div_after;

  assign cur_mode = st.sleep_ctrl[sysclk_pkg::MODE_SELECT_LSB +: sysclk_pkg::MODE_SELECT_W];

  // ------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------
  always_comb begin
    axi_rsp         = '0;
    axi_rsp.awready = clk_en && !st.aw_got && !st.bvalid;
    axi_rsp.wready  = clk_en && !st.w_got && !st.bvalid;
    axi_rsp.bvalid  = st.bvalid;
    axi_rsp.bresp   = st.bresp;
    axi_rsp.arready = clk_en && !st.rvalid;
    axi_rsp.rvalid  = st.rvalid;
    axi_rsp.rdata   = st.rdata;
    axi_rsp.rresp   = st.rresp;
  end

  assign aw_take  = axi_req.awvalid && axi_rsp.awready;
  assign w_take   = axi_req.wvalid && axi_rsp.wready;
  assign ar_take  = axi_req.arvalid && axi_rsp.arready;
  assign wr_go    = (st.aw_got || aw_take) && (st.w_got || w_take);
  assign wr_addr  = st.aw_got ? st.aw_addr : axi_req.awaddr;
  assign wr_data  = st.w_got ? st.w_data : axi_req.wdata;
  assign wr_lane0 = st.w_got ? st.w_strb[0] : axi_req.wstrb[0];
  assign wr_byte  = wr_data[7:0];

  // ------------------------------------------------------------
  // Divider arithmetic
  // ------------------------------------------------------------
  assign period_last = 8'((9'h001 << st.active_div) - 9'h001);
  assign cnt_after   = (st.div_cnt == period_last) ? 8'h00 : 8'(st.div_cnt + 8'h01);
  // New factor takes effect only at a period boundary, so no runt pulse appears
  assign div_after   = (cnt_after == 8'h00) ? clamp_div(st.div_sel) : st.active_div;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.wake_resume = 1'b0;
    next_st.adc_start   = 1'b0;

    // Write channel capture and execution
    if (aw_take) begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = axi_req.awaddr;
    end
    if (w_take) begin
      next_st.w_got  = 1'b1;
      next_st.w_data = axi_req.wdata;
      next_st.w_strb = axi_req.wstrb;
    end
    if (st.bvalid && axi_req.bready) begin
      next_st.bvalid = 1'b0;
    end

    // Change window countdown
    if (st.change_enable) begin
      if (st.change_cnt == 3'h1) begin
        next_st.change_enable = 1'b0;
        next_st.change_cnt    = 3'h0;
      end else begin
        next_st.change_cnt = 3'(st.change_cnt - 3'h1);
      end
    end

    if (wr_go && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = sysclk_pkg::RESP_OKAY;
      case (wr_addr)
        sysclk_pkg::CLOCK_DIVIDER_CONTROL_OFFSET: begin
          if (wr_lane0) begin
            if (wr_byte == sysclk_pkg::UNLOCK_PATTERN) begin
              if (!st.change_enable) begin
                next_st.change_enable = 1'b1;
                next_st.change_cnt    = sysclk_pkg::CHANGE_WINDOW_CYCLES;
              end
              // A rewrite inside the window keeps the running countdown
            end else if (st.change_enable && !wr_byte[sysclk_pkg::DIVIDER_CHANGE_ENABLE_BIT]) begin
              next_st.div_sel       = wr_byte[sysclk_pkg::DIVISION_SELECT_LSB +:
                                              sysclk_pkg::DIVISION_SELECT_W];
              next_st.change_enable = 1'b0;
              next_st.change_cnt    = 3'h0;
            end
          end
        end
        sysclk_pkg::SLEEP_CONTROL_OFFSET: begin
          if (wr_lane0) begin
            next_st.sleep_ctrl = wr_byte[3:0];
          end
        end
        sysclk_pkg::PORT_CONFIG_OFFSET: begin
          if (wr_lane0) begin
            next_st.osc_enable = wr_byte[sysclk_pkg::OSC_ENABLE_BIT];
            next_st.ext_clock  = wr_byte[sysclk_pkg::EXT_CLOCK_BIT];
          end
        end
        sysclk_pkg::STATUS_OFFSET: begin
          next_st.bresp = sysclk_pkg::RESP_OKAY;
        end
        default: begin
          next_st.bresp = sysclk_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Read channel
    if (st.rvalid && axi_req.rready) begin
      next_st.rvalid = 1'b0;
    end
    if (ar_take) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = sysclk_pkg::RESP_OKAY;
      next_st.rdata  = '0;
      case (axi_req.araddr)
        sysclk_pkg::CLOCK_DIVIDER_CONTROL_OFFSET: begin
          next_st.rdata[sysclk_pkg::DIVIDER_CHANGE_ENABLE_BIT] = st.change_enable;
          next_st.rdata[3:0] = st.div_sel;
        end
        sysclk_pkg::SLEEP_CONTROL_OFFSET: begin
          next_st.rdata[3:0] = st.sleep_ctrl;
        end
        sysclk_pkg::PORT_CONFIG_OFFSET: begin
          next_st.rdata[sysclk_pkg::OSC_ENABLE_BIT] = st.osc_enable;
          next_st.rdata[sysclk_pkg::EXT_CLOCK_BIT]  = st.ext_clock;
        end
        sysclk_pkg::STATUS_OFFSET: begin
          next_st.rdata[sysclk_pkg::STATUS_ACTIVE_DIV_LSB +: 4] = st.active_div;
          next_st.rdata[sysclk_pkg::STATUS_PHASE_LSB +: 2]      = st.phase;
        end
        default: begin
          next_st.rresp = sysclk_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Strap is loaded once the second stage holds the fuse, one edge after settling
    next_st.strap_s1 = divide_by_eight_fuse;
    next_st.strap_s2 = st.strap_s1;
    if (!(&st.strap_cnt)) begin
      next_st.strap_cnt = 2'(st.strap_cnt + 2'h1);
      if (st.strap_cnt == sysclk_pkg::STRAP_SETTLE_CYCLES) begin
        next_st.div_sel = st.strap_s2 ? sysclk_pkg::DIVISION_SELECT_FUSED
                                      : sysclk_pkg::DIVISION_SELECT_RESET;
      end
    end

    // Shared divider for all synchronous clock domains
    next_st.div_cnt    = cnt_after;
    next_st.active_div = div_after;
    if (div_after == 4'h0) begin
      next_st.div_cnt = 8'h00;
      next_st.div_clk = 1'b1;
    end else begin
      // High during the first half of each divided period
      next_st.div_clk = (cnt_after < 8'(9'h001 << (div_after - 4'h1)));
    end

    // Sleep sequencing
    case (st.phase)
      sysclk_pkg::PH_RUN: begin
        next_st.gates = '1;
        if (sleep_instr && st.sleep_ctrl[sysclk_pkg::SLEEP_ENABLE_BIT] &&
            mode_legal(cur_mode)) begin
          next_st.phase = sysclk_pkg::PH_SLEEP;
          next_st.gates = gates_for(cur_mode);
          next_st.adc_start = adc_enabled && ((cur_mode == sysclk_pkg::MODE_IDLE) ||
                              (cur_mode == sysclk_pkg::MODE_NOISE_REDUCTION));
        end
      end
      sysclk_pkg::PH_SLEEP: begin
        if (wake_irq) begin
          if ((cur_mode == sysclk_pkg::MODE_IDLE) ||
              (cur_mode == sysclk_pkg::MODE_NOISE_REDUCTION) || (STARTUP_COUNT == 16'h0000)) begin
            next_st.phase    = sysclk_pkg::PH_HOLD;
            next_st.wait_cnt = 16'(sysclk_pkg::WAKE_HOLD_CYCLES);
            next_st.gates    = '1;
            next_st.gates.core_clock           = 1'b0;
            next_st.gates.program_memory_clock = 1'b0;
          end else begin
            next_st.phase    = sysclk_pkg::PH_START;
            next_st.wait_cnt = STARTUP_COUNT;
          end
        end
      end
      sysclk_pkg::PH_START: begin
        if (st.wait_cnt == 16'h0001) begin
          next_st.phase    = sysclk_pkg::PH_HOLD;
          next_st.wait_cnt = 16'(sysclk_pkg::WAKE_HOLD_CYCLES);
          next_st.gates    = '1;
          next_st.gates.core_clock           = 1'b0;
          next_st.gates.program_memory_clock = 1'b0;
        end else begin
          next_st.wait_cnt = 16'(st.wait_cnt - 16'h0001);
        end
      end
      sysclk_pkg::PH_HOLD: begin
        if (st.wait_cnt == 16'h0001) begin
          // Only clocks were stopped, so core and memory contents carry on
          next_st.phase       = sysclk_pkg::PH_RUN;
          next_st.wait_cnt    = 16'h0000;
          next_st.gates       = '1;
          next_st.wake_resume = 1'b1;
        end else begin
          next_st.wait_cnt = 16'(st.wait_cnt - 16'h0001);
        end
      end
      default: begin
        next_st.phase = sysclk_pkg::PH_RUN;
        next_st.gates = '1;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Chip reset returns the sequencer to run from the reset vector
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st            <= '0;
      st.div_sel    <= sysclk_pkg::DIVISION_SELECT_RESET;
      st.active_div <= sysclk_pkg::DIVISION_SELECT_RESET;
      st.div_clk    <= 1'b1;
      st.sleep_ctrl <= sysclk_pkg::SLEEP_CONTROL_RESET;
      st.phase      <= sysclk_pkg::PH_RUN;
      st.gates      <= '1;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Fuse is static, so the pin works straight through reset
  assign system_clock_output_oe  = clock_output_fuse;
  assign system_clock_output_pin = clock_output_fuse &&
                                   ((st.active_div == 4'h0) ? clk : st.div_clk);

  assign port_g_bit_four_free  = !st.osc_enable && !st.ext_clock;
  assign port_g_bit_three_free = !st.osc_enable || st.ext_clock;

  assign sys_tick             = clk_en && (st.div_cnt == 8'h00);
  assign clock_gates          = st.gates;
  assign core_halted          = (st.phase != sysclk_pkg::PH_RUN);
  assign wake_resume          = st.wake_resume;
  assign adc_start_conversion = st.adc_start;

endmodule

//--- sysclk_sva.sv
// Concurrent assertions for the clock and sleep control block
`timescale 1ns/1ps
module sysclk_sva (
  input wire logic                     clk,
  input wire logic                     rst_b,
  input wire logic                     clock_output_fuse,
  input wire logic                     sleep_instr,
  input wire logic                     adc_enabled,
  input wire logic                     system_clock_output_pin,
  input wire logic                     system_clock_output_oe,
  input wire logic                     port_g_bit_four_free,
  input wire logic                     port_g_bit_three_free,
  input wire sysclk_pkg::clock_gates_t clock_gates,
  input wire logic                     core_halted,
  input wire logic                     wake_resume,
  input wire logic                     adc_start_conversion
);
  // ------------------------------------------------------------
  // Pin, sleep and wake relations
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence halt_s; $rose(core_halted); endsequence
  sequence resume_s; wake_resume && !core_halted; endsequence
  oe_fuse_a: assert property (system_clock_output_oe == clock_output_fuse)
    else $error("clock pin enable differs from fuse");
  pin_off_a: assert property (!clock_output_fuse |-> !system_clock_output_pin)
    else $error("clock pin active without fuse");
  port_share_a: assert property (port_g_bit_four_free |-> port_g_bit_three_free)
    else $error("second oscillator pin lost while first is free");
  halt_cause_a: assert property (halt_s |-> $past(sleep_instr))
    else $error("core halted without sleep instruction");
  wake_hold_a: assert property (wake_resume |-> $past(core_halted, 4) ##0 resume_s)
    else $error("resume without four held cycles");
  resume_pulse_a: assert property (wake_resume |=> !wake_resume)
    else $error("resume pulse longer than one cycle");
  adc_start_a: assert property (adc_start_conversion |-> $past(sleep_instr) && $past(adc_enabled))
    else $error("conversion start without sleep entry");
  idle_gates_a: assert property (adc_start_conversion |-> !clock_gates.core_clock &&
    !clock_gates.program_memory_clock && clock_gates.converter_clock)
    else $error("wrong clock gates on sleep entry");
  reset_run_a: assert property ($rose(rst_b) |-> !core_halted && clock_gates == 5'h1f)
    else $error("not running after reset");
endmodule
bind sysclk_prescale_sleep_ctrl sysclk_sva sysclk_sva_inst (
  .clk(clk), .rst_b(rst_b), .clock_output_fuse(clock_output_fuse),
  .sleep_instr(sleep_instr), .adc_enabled(adc_enabled),
  .system_clock_output_pin(system_clock_output_pin),
  .system_clock_output_oe(system_clock_output_oe), .clock_gates(clock_gates),
  .port_g_bit_four_free(port_g_bit_four_free), .port_g_bit_three_free(port_g_bit_three_free),
  .core_halted(core_halted), .wake_resume(wake_resume),
  .adc_start_conversion(adc_start_conversion));

//--- tb.sv
// Self-checking testbench for the clock and sleep control block
`timescale 1ns/1ps
module tb;
  logic                     clk, rst_b, clock_output_fuse, divide_by_eight_fuse, clk_en;
  logic                     sleep_instr, wake_irq, adc_enabled, pin, oe, four_free;
  logic                     three_free, sys_tick, core_halted, wake_resume, adc_start;
  sysclk_pkg::axi_req_t     axi_req;
  sysclk_pkg::axi_rsp_t     axi_rsp;
  sysclk_pkg::clock_gates_t clock_gates;
  int                       bad_count, comparisons, n;
  sysclk_prescale_sleep_ctrl #(.STARTUP_CYCLES(2)) sysclk_prescale_sleep_ctrl_inst (
    .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .clock_output_fuse(clock_output_fuse), .divide_by_eight_fuse(divide_by_eight_fuse),
    .sleep_instr(sleep_instr), .wake_irq(wake_irq), .adc_enabled(adc_enabled),
    .system_clock_output_pin(pin), .system_clock_output_oe(oe),
    .port_g_bit_four_free(four_free), .port_g_bit_three_free(three_free),
    .sys_tick(sys_tick), .clock_gates(clock_gates), .core_halted(core_halted),
    .wake_resume(wake_resume), .adc_start_conversion(adc_start));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
    logic aw_hit;
    logic w_hit;
    axi_req.awaddr <= a;
    axi_req.wdata <= {24'h0, d};
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    repeat (50) begin
      @(negedge clk);
      if (axi_rsp.bvalid) break;
      aw_hit = axi_req.awvalid && axi_rsp.awready;
      w_hit = axi_req.wvalid && axi_rsp.wready;
      @(posedge clk);
      if (aw_hit) axi_req.awvalid <= 1'b0;
      if (w_hit) axi_req.wvalid <= 1'b0;
    end
    check(axi_rsp.bvalid, 1'b1);
    check(axi_rsp.bresp, r);
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    logic ar_hit;
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    repeat (50) begin
      @(negedge clk);
      if (axi_rsp.rvalid) break;
      ar_hit = axi_req.arvalid && axi_rsp.arready;
      @(posedge clk);
      if (ar_hit) axi_req.arvalid <= 1'b0;
    end
    check(axi_rsp.rvalid, 1'b1);
    check(axi_rsp.rdata, e);
    check(axi_rsp.rresp, r);
    @(posedge clk);
  endtask
  task automatic set_div(input logic [7:0] d);
    wr(8'h00, sysclk_pkg::UNLOCK_PATTERN);
    wr(8'h00, d);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_unlock;
    wr(8'h00, 8'h81);
    wr(8'h00, 8'h02);
    rdc(8'h00, 32'h0);
    wr(8'h00, 8'h80);
    rdc(8'h00, 32'h80);
    @(posedge clk);
    wr(8'h00, 8'h05);
    rdc(8'h00, 32'h0);
    wr(8'h00, 8'h80);
    wr(8'h00, 8'h80);
    @(posedge clk);
    wr(8'h00, 8'h05);
    rdc(8'h00, 32'h0);
    rdc(8'h10, 32'h0, sysclk_pkg::RESP_SLVERR);
    wr(8'h10, 8'h01, sysclk_pkg::RESP_SLVERR);
  endtask
  task automatic t_div;
    int ticks;
    int highs;
    for (n = 0; n < 10; n++) begin
      set_div(n[7:0]);
      rdc(8'h00, n);
      if (n < 9) begin
        repeat (260) @(posedge clk);
        ticks = 0;
        highs = 0;
        repeat (512) begin
          @(negedge clk);
          ticks += sys_tick;
          highs += pin;
        end
        check(ticks, 512 >> n);
        if (n > 0) check(highs, 256);
        @(posedge clk);
      end
    end
  endtask
  task automatic t_sleep(input logic [2:0] m, input logic se);
    logic       ok;
    logic [4:0] g;
    int         k;
    ok = se && (m < 4 || m == 6);
    g = !ok ? 5'h1f : m == 0 ? 5'h07 : m == 1 ? 5'h03 : m == 3 ? 5'h01 : 5'h00;
    wr(8'h04, {4'h0, m, se});
    sleep_instr <= 1'b1;
    @(posedge clk);
    sleep_instr <= 1'b0;
    #1;
    check(core_halted, ok);
    check(clock_gates, g);
    check(adc_start, ok && m < 2);
    if (ok) begin
      @(posedge clk);
      wake_irq <= 1'b1;
      @(posedge clk);
      wake_irq <= 1'b0;
      for (k = 1; k < 40; k++) begin
        #1;
        if (wake_resume) break;
        @(posedge clk);
      end
      check(k, m < 2 ? 5 : 7);
    end
    @(posedge clk);
  endtask
  initial begin
    #1000000;
    bad_count++;
    end_of_test;
  end
  initial begin
    bad_count = 0;
    comparisons = 0;
    axi_req = '0;
    axi_req.bready = 1'b1;
    axi_req.rready = 1'b1;
    axi_req.wstrb = 4'hf;
    clk_en = 1'b1;
    rst_b = 1'b0;
    clock_output_fuse = 1'b1;
    divide_by_eight_fuse = 1'b0;
    sleep_instr = 1'b0;
    wake_irq = 1'b0;
    adc_enabled = 1'b1;
    #15 check(pin, 1'b1);
    #10 check(pin, 1'b0);
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(8'h00, 32'h0);
    t_unlock;
    t_div;
    wr(8'h00, sysclk_pkg::UNLOCK_PATTERN);
    clk_en <= 1'b0;
    repeat (8) @(posedge clk);
    check(axi_rsp.awready, 1'b0);
    clk_en <= 1'b1;
    wr(8'h00, 8'h02);
    rdc(8'h00, 32'h2);
    for (n = 0; n < 4; n++) begin
      wr(8'h08, n[7:0]);
      check({four_free, three_free}, 8'h53 >> (2 * n) & 2'h3);
    end
    for (n = 0; n < 8; n++) t_sleep(n[2:0], 1'b1);
    t_sleep(3'h0, 1'b0);
    rst_b <= 1'b0;
    divide_by_eight_fuse <= 1'b1;
    clock_output_fuse <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    check({oe, pin}, 2'h0);
    rdc(8'h00, 32'h3);
    end_of_test;
  end
endmodule
